// >>> hdl/pdr_consts.svh
// Constants for the port drive, duty and rotary configuration block.
// Assumes a 100 MHz reference clock.
`ifndef PDR_CONSTS_SVH
`define PDR_CONSTS_SVH
`define PDR_ADDR_SINK 8'h43
`define PDR_ADDR_STYLE 8'h44
`define PDR_ADDR_DUTY 8'h45
`define PDR_ADDR_ROT 8'h46
`define PDR_ADDR_COUNT 8'h4A
`define PDR_SINK_FIXED 8'hC0
`define PDR_SINK_LSB 0
`define PDR_SINK_MSB 1
`define PDR_RST_SINK 2'h0
`define PDR_RST_STYLE 8'h00
`define PDR_RST_DUTY 8'h00
`define PDR_RST_ROT 8'h00
`define PDR_DUTY_FULL 8'hFF
`define PDR_ROT_DEB_LSB 0
`define PDR_ROT_DEB_MSB 3
`define PDR_ROT_THR_LSB 4
`define PDR_ROT_THR_MSB 6
`define PDR_ROT_TYPE 7
`define PDR_CLK_NS 10
`define PDR_T_MS_NS 1000000
`define PDR_T_STEP_MS 25
`endif

// >>> hdl/pdr_pkg.sv
// Types for the port drive, duty and rotary configuration block.
// Shared by the top module and the verification side.
package pdr_pkg;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pdr_req_s;

  typedef enum logic [1:0] {
    PDR_IDLE = 2'b00,
    PDR_TIMING = 2'b01,
    PDR_FIRED = 2'b11
  } pdr_tmr_e;
endpackage : pdr_pkg

// >>> hdl/pdr_top.sv
// Port drive style, sink level, shared duty and rotary switch logic.
// Assumes the serial front end delivers decoded register strobes, and
// that global mode, common-select bits and individual duties come from
// neighbouring register logic.
// Function
// - The two-bit sink field selects 5, 6.67, 10 or 20 mA and resets to 00.
// - Each port has a style bit, 0 constant-current and 1 plain open drain, reset 0.
// - Shared duty N gives an on-ratio of N/256 for codes 1 to 254.
// - Shared duty all ones gives a full 256/256 on-ratio.
// - Shared duty resets to zero, meaning the output is off.
// - Low four rotary bits give the debounce in ms, zero meaning none.
// - Threshold field zero never raises the port interrupt line.
// - With type bit 0 the interrupt rises when the count reaches plus or minus N.
// - With type bit 1 the interrupt rises N times 25 ms after the first event.
// - Rotary logic works only while the global rotary mode bit is set.
// - The step count is an 8-bit signed value readable by software.
// - A port uses the shared duty only when its common-select bit is set.
`timescale 1ns/1ns
`include "pdr_consts.svh"
module pdr_top import pdr_pkg::*; #(
  parameter int PORTS = 8,
  parameter int MS_CYCLES = `PDR_T_MS_NS / `PDR_CLK_NS
) (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire pdr_req_s i_reg,
  input wire logic i_rotary_mode,
  input wire logic [PORTS-1:0] i_common_sel,
  input wire logic [PORTS*8-1:0] i_port_duty,
  input wire logic i_rotary_input_a,
  input wire logic i_rotary_input_b,
  output logic [7:0] o_reg_rdata,
  output logic [1:0] o_sink_level,
  output logic [PORTS-1:0] o_port_style,
  output logic [PORTS-1:0] o_port_sink,
  output logic [7:0] o_rotary_count,
  output logic o_port_interrupt_line
);
  logic [1:0] sink_r;
  logic [PORTS-1:0] style_r;
  logic [7:0] duty_r;
  logic [7:0] rot_r;
  logic [7:0] slot_r;
  logic [31:0] ms_cnt_r;
  logic [1:0] stable_r;
  logic [1:0] cand_r;
  logic [3:0] deb_r;
  logic signed [7:0] count_r;
  logic intr_r;
  logic [7:0] tmr_r;
  pdr_tmr_e tmr_st_r;
  logic [PORTS-1:0] sink_nxt;
  logic [7:0] rdata_nxt;

  wire wr_sink = i_reg.wr && (i_reg.addr == `PDR_ADDR_SINK);
  wire wr_style = i_reg.wr && (i_reg.addr == `PDR_ADDR_STYLE);
  wire wr_duty = i_reg.wr && (i_reg.addr == `PDR_ADDR_DUTY);
  wire wr_rot = i_reg.wr && (i_reg.addr == `PDR_ADDR_ROT);
  wire rd_count = i_reg.rd && (i_reg.addr == `PDR_ADDR_COUNT);
  wire [3:0] deb_ms = rot_r[`PDR_ROT_DEB_MSB:`PDR_ROT_DEB_LSB];
  wire [2:0] thr = rot_r[`PDR_ROT_THR_MSB:`PDR_ROT_THR_LSB];
  wire tmr_mode = rot_r[`PDR_ROT_TYPE];
  wire ms_tick = (ms_cnt_r == 32'(MS_CYCLES - 1));
  wire [1:0] raw = {i_rotary_input_b, i_rotary_input_a};

  // Debounce restarts whenever the raw pair moves off the candidate
  wire raw_moved = (raw != cand_r);
  wire deb_done = (deb_ms == 4'h0) || (deb_r >= deb_ms);
  wire accept = i_rotary_mode && !raw_moved && (cand_r != stable_r) && deb_done;
  // Gray step direction; a double change is dropped as a glitch
  wire step_up = accept && (cand_r == {stable_r[0], ~stable_r[1]});
  wire step_dn = accept && (cand_r == {~stable_r[0], stable_r[1]});
  wire step = step_up || step_dn;
  wire signed [7:0] count_base = rd_count ? 8'sh00 : count_r;
  wire signed [7:0] count_new = step_up ? count_base + 8'sh01 :
                                step_dn ? count_base - 8'sh01 : count_base;
  wire [7:0] count_mag = count_new[7] ? 8'(-count_new) : 8'(count_new);
  wire thr_hit = !tmr_mode && (thr != 3'h0) && (count_mag >= {5'h00, thr});
  wire [7:0] tmr_limit = 8'(thr * `PDR_T_STEP_MS);
  wire tmr_expire = (tmr_st_r == PDR_TIMING) && ms_tick && (tmr_r + 8'h01 >= tmr_limit);
  wire int_set = i_rotary_mode && (thr != 3'h0) && (thr_hit || tmr_expire);
  wire int_clr = rd_count || !i_rotary_mode || (thr == 3'h0);
  wire tmr_start = tmr_mode && step && (thr != 3'h0);
  wire tmr_abort = !tmr_mode || !i_rotary_mode;
  wire deb_clr = raw_moved || accept;
  wire deb_inc = ms_tick && (deb_r != 4'hF);
  wire [7:0] slot_nxt = slot_r + 8'h01;
  wire [31:0] ms_cnt_nxt = ms_tick ? 32'h0000_0000 : ms_cnt_r + 32'h0000_0001;

  // Period of 256 slots shared by every port
  genvar g;
  generate
    for (g = 0; g < PORTS; g++) begin : g_port
      wire [7:0] pd = i_port_duty[g*8 +: 8];
      wire [7:0] n = i_common_sel[g] ? duty_r : pd;
      assign sink_nxt[g] = (n == `PDR_DUTY_FULL) || (slot_r < n);
    end
  endgenerate

  always_comb begin
    unique case (i_reg.addr)
      `PDR_ADDR_SINK: rdata_nxt = `PDR_SINK_FIXED | {6'h00, sink_r};
      `PDR_ADDR_STYLE: rdata_nxt = style_r;
      `PDR_ADDR_DUTY: rdata_nxt = duty_r;
      `PDR_ADDR_ROT: rdata_nxt = rot_r;
      `PDR_ADDR_COUNT: rdata_nxt = count_r;
      default: rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      sink_r <= `PDR_RST_SINK;
      style_r <= `PDR_RST_STYLE;
      duty_r <= `PDR_RST_DUTY;
      rot_r <= `PDR_RST_ROT;
    end else begin
      if (wr_sink) sink_r <= i_reg.wdata[`PDR_SINK_MSB:`PDR_SINK_LSB];
      if (wr_style) style_r <= i_reg.wdata;
      if (wr_duty) duty_r <= i_reg.wdata;
      if (wr_rot) rot_r <= i_reg.wdata;
    end
  end

  // Read data holds between reads so a slow host may fetch it late
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg.rd) begin
      o_reg_rdata <= rdata_nxt;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      slot_r <= 8'h00;
      ms_cnt_r <= 32'h0000_0000;
      o_port_sink <= '0;
    end else begin
      slot_r <= slot_nxt;
      ms_cnt_r <= ms_cnt_nxt;
      o_port_sink <= sink_nxt;
    end
  end

  // Debounce counts whole ms ticks, so the first ms may be short by up to one tick
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      stable_r <= 2'h0;
      cand_r <= 2'h0;
      deb_r <= 4'h0;
    end else if (!i_rotary_mode) begin
      stable_r <= raw;
      cand_r <= raw;
      deb_r <= 4'h0;
    end else begin
      cand_r <= raw;
      if (deb_clr) deb_r <= 4'h0;
      else if (deb_inc) deb_r <= deb_r + 4'h1;
      if (accept) stable_r <= cand_r;
    end
  end

  // A step in the reading cycle survives the clear
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      count_r <= 8'sh00;
    end else begin
      count_r <= count_new;
    end
  end

  // Set wins over clear in the same cycle
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      intr_r <= 1'b0;
    end else if (int_set) begin
      intr_r <= 1'b1;
    end else if (int_clr) begin
      intr_r <= 1'b0;
    end
  end

  // Re-armed by a count read or by tmr_abort, so one burst of turns gives one interrupt
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      tmr_r <= 8'h00;
      tmr_st_r <= PDR_IDLE;
    end else begin
      unique case (tmr_st_r)
        PDR_IDLE: begin
          tmr_r <= 8'h00;
          if (tmr_start) tmr_st_r <= PDR_TIMING;
        end
        PDR_TIMING: begin
          if (tmr_abort) tmr_st_r <= PDR_IDLE;
          else if (tmr_expire) tmr_st_r <= PDR_FIRED;
          else if (ms_tick) tmr_r <= tmr_r + 8'h01;
        end
        PDR_FIRED: begin
          if (rd_count || tmr_abort) tmr_st_r <= PDR_IDLE;
        end
        default: tmr_st_r <= PDR_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_sink_level <= `PDR_RST_SINK;
      o_port_style <= `PDR_RST_STYLE;
      o_rotary_count <= 8'h00;
      o_port_interrupt_line <= 1'b0;
    end else begin
      o_sink_level <= sink_r;
      o_port_style <= style_r;
      o_rotary_count <= count_r;
      o_port_interrupt_line <= intr_r;
    end
  end
endmodule : pdr_top

// >>> dv/pdr_rot_model.sv
// Rotary switch model: walks a two-bit gray code one step per request.
// Assumes step pulses one clock wide, forward when dir is 0.
`timescale 1ns/1ns
module pdr_rot_model (
  input wire logic i_clk,
  input wire logic i_step,
  input wire logic i_dir,
  output logic o_a,
  output logic o_b
);
  logic [1:0] pos_r = 2'h0;
  always_ff @(posedge i_clk) if (i_step) pos_r <= i_dir ? pos_r - 2'h1 : pos_r + 2'h1;
  // Gray order 00, 01, 11, 10 so only one line moves per step
  assign {o_b, o_a} = pos_r ^ {1'b0, pos_r[1]};
endmodule : pdr_rot_model

// >>> dv/pdr_top_sva.sv
// Port checker for pdr_top.
// Assumes host writes are mirrored here to know the setup fields.
`timescale 1ns/1ns
module pdr_top_sva import pdr_pkg::*; (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire pdr_req_s i_reg,
  input wire logic i_rotary_mode,
  input wire logic [7:0] i_common_sel,
  input wire logic [1:0] o_sink_level,
  input wire logic [7:0] o_port_style,
  input wire logic [7:0] o_port_sink,
  input wire logic [7:0] o_rotary_count,
  input wire logic o_port_interrupt_line
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  logic [7:0] rot_r;
  logic [7:0] duty_r;
  wire [7:0] wd = i_reg.wdata;
  wire thr0 = rot_r[6:4] == 3'h0;
  wire [7:0] mag = o_rotary_count[7] ? 8'h00 - o_rotary_count : o_rotary_count;
  wire irq = o_port_interrupt_line;
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      rot_r <= 8'h00;
      duty_r <= 8'h00;
    end else if (i_reg.wr && i_reg.addr == 8'h46) begin
      rot_r <= wd;
    end else if (i_reg.wr && i_reg.addr == 8'h45) begin
      duty_r <= wd;
    end
  end
  sequence count_rd;
    i_reg.rd && i_reg.addr == 8'h4A && !rot_r[7];
  endsequence
  sequence duty_is(logic [7:0] v);
    (&i_common_sel && duty_r == v)[*3];
  endsequence
  chk_sink_write: assert property (i_reg.wr && i_reg.addr == 8'h43 |-> ##2
    {6'h00, o_sink_level} == ($past(wd, 2) & 8'h03)) else $error("sink level not written");
  chk_style_write: assert property (i_reg.wr && i_reg.addr == 8'h44 |-> ##2
    o_port_style == $past(wd, 2)) else $error("port style not written");
  chk_full_duty: assert property (duty_is(8'hFF) |-> &o_port_sink)
    else $error("full duty not always on");
  chk_zero_duty: assert property (duty_is(8'h00) |-> o_port_sink == 8'h00)
    else $error("zero duty not off");
  chk_thr_zero: assert property (thr0 && $past(thr0) && $past(thr0, 2) |-> !irq)
    else $error("interrupt with zero threshold");
  chk_count_thr: assert property ($rose(irq) && !rot_r[7] |-> mag >= {5'h00, rot_r[6:4]})
    else $error("interrupt below count threshold");
  chk_mode_off: assert property (!i_rotary_mode [*3] |-> !irq)
    else $error("interrupt with rotary mode off");
  chk_count_read: assert property (count_rd |-> ##2 o_rotary_count inside {8'h00, 8'h01, 8'hFF}
    && (!irq || o_rotary_count != 8'h00)) else $error("count read did not clear");
endmodule : pdr_top_sva
bind pdr_top pdr_top_sva i_pdr_top_sva (.i_ref_clk, .i_sys_rst, .i_reg, .i_rotary_mode,
  .i_common_sel, .o_sink_level, .o_port_style, .o_port_sink, .o_rotary_count,
  .o_port_interrupt_line);

// >>> dv/tb.sv
// Bench for pdr_top: register accesses, duty sampling and rotary steps.
// Assumes MS_CYCLES of 10, so one ms tick is ten clocks.
`timescale 1ns/1ns
module tb;
  import pdr_pkg::*;
  logic clk = 0, rst = 1, mode = 0, stp = 0, dir = 0, a, b, irq;
  logic [7:0] sel = 8'hFF, rdata, cnt, sty, pw;
  logic [1:0] snk;
  pdr_req_s req = '0;
  int errors = 0, checked = 0, cyc = 0;
  pdr_top #(.MS_CYCLES(10)) i_pdr_top (.i_ref_clk(clk), .i_sys_rst(rst), .i_reg(req),
    .i_rotary_mode(mode), .i_common_sel(sel), .i_port_duty({8{8'h10}}),
    .i_rotary_input_a(a), .i_rotary_input_b(b), .o_reg_rdata(rdata), .o_sink_level(snk),
    .o_port_style(sty), .o_port_sink(pw), .o_rotary_count(cnt), .o_port_interrupt_line(irq));
  pdr_rot_model i_pdr_rot_model (.i_clk(clk), .i_step(stp), .i_dir(dir), .o_a(a), .o_b(b));
  initial forever #5 clk = ~clk;
  task automatic ck(string n, logic [8:0] s, logic [8:0] e);
    checked++;
    if (s !== e) begin
      errors++;
      $display("Error %s exp %h got %h", n, e, s);
    end
  endtask : ck
  task automatic ac(logic w, logic [7:0] ad, logic [7:0] d);
    @(posedge clk) #1 req = '{w, !w, ad, d};
    @(posedge clk) #1 req = '0;
  endtask : ac
  task automatic rd(logic [7:0] ad, logic [7:0] e);
    ac(1'b0, ad, 8'h00);
    ck("rdata", 9'(rdata), 9'(e));
  endtask : rd
  task automatic st(logic d, int w);
    @(posedge clk) #1 {stp, dir} = {1'b1, d};
    @(posedge clk) #1 stp = 0;
    repeat (w) @(negedge clk);
  endtask : st
  // Settle one whole period first, since a change mid-period mixes two ratios
  task automatic duty(logic [7:0] d, logic [8:0] e);
    int n = 0;
    ac(1'b1, 8'h45, d);
    repeat (256) @(negedge clk);
    repeat (256) @(negedge clk) n += pw[0];
    ck("duty", 9'(n), e);
  endtask : duty
  task wrap_up();
    if (errors == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up
  always @(posedge clk) begin
    cyc++;
    if (cyc == 10000) begin
      errors++;
      wrap_up();
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    #1 rst = 0;
    rd(8'h43, 8'hC0);
    rd(8'h45, 8'h00);
    rd(8'h47, 8'h00);
    for (int i = 0; i < 4; i++) begin
      ac(1'b1, 8'h43, 8'(i));
      @(posedge clk) #1;
      ck("sink", 9'(snk), 9'(i));
    end
    rd(8'h43, 8'hC3);
    ac(1'b1, 8'h44, 8'hA5);
    @(posedge clk) #1;
    ck("style", 9'(sty), 9'h0A5);
    duty(8'h00, 9'h000);
    duty(8'h01, 9'h001);
    duty(8'hFE, 9'h0FE);
    duty(8'hFF, 9'h100);
    @(posedge clk) #1 sel = 8'hFE;
    duty(8'hFF, 9'h010);
    @(posedge clk) #1 mode = 1;
    ac(1'b1, 8'h46, 8'h30);
    st(0, 6);
    st(0, 6);
    ck("irq", 9'(irq), 9'h000);
    st(0, 6);
    ck("irq", 9'(irq), 9'h001);
    ck("count", 9'(cnt), 9'h003);
    rd(8'h4A, 8'h03);
    @(posedge clk) #1;
    ck("irq", 9'(irq), 9'h000);
    repeat (3) st(1, 6);
    ck("irq", 9'(irq), 9'h001);
    ck("count", 9'(cnt), 9'h0FD);
    rd(8'h4A, 8'hFD);
    ac(1'b1, 8'h46, 8'h00);
    repeat (4) st(0, 6);
    ck("irq", 9'(irq), 9'h000);
    rd(8'h4A, 8'h04);
    @(posedge clk) #1 mode = 0;
    st(0, 6);
    st(1, 6);
    rd(8'h4A, 8'h00);
    @(posedge clk) #1 mode = 1;
    ac(1'b1, 8'h46, 8'h02);
    st(0, 2);
    st(1, 30);
    rd(8'h4A, 8'h00);
    st(0, 30);
    rd(8'h4A, 8'h01);
    ac(1'b1, 8'h46, 8'h90);
    st(0, 200);
    ck("irq", 9'(irq), 9'h000);
    repeat (100) @(negedge clk);
    ck("irq", 9'(irq), 9'h001);
    wrap_up();
  end
endmodule : tb
